/* File: src/ppp_params.svh */
`ifndef PPP_PARAMS_SVH
`define PPP_PARAMS_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PPP_CLK_PERIOD_NS 4
`define PPP_ENTRY_HOLD_NS 100
`define PPP_ENTRY_HOLD_CYC ((`PPP_ENTRY_HOLD_NS + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)
`define PPP_ENTRY_TOGGLES 4'h6
`define PPP_BUSY_CYC 16'h0100
// ------------------------------------------------------------
// Action select codes
// ------------------------------------------------------------
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
// ------------------------------------------------------------
// Command bytes
// ------------------------------------------------------------
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_PROG 8'h10
`define PPP_CMD_WR_EE 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_PROG 8'h02
`define PPP_CMD_RD_EE 8'h03
// ------------------------------------------------------------
// Geometry and fields
// ------------------------------------------------------------
`define PPP_PROG_WORDS 4096
`define PPP_PROG_PAGE_WORDS 32
`define PPP_EE_BYTES 512
`define PPP_EE_PAGE_BYTES 4
`define PPP_FUSEH_KEEP_EE 3
`define PPP_FUSE_LO_RST 8'hE1
`define PPP_FUSE_HI_RST 8'hD9
`define PPP_LOCK_RST 8'hFF
`define PPP_SIG_LAST 2'h2
`define PPP_ERASED 8'hFF
`endif

/* File: src/ppp_pkg.sv */
package ppp_pkg;
   typedef enum logic [1:0] {PPP_OFF, PPP_ARM, PPP_HOLD, PPP_ON} ppp_mode_t;
   typedef enum logic [1:0] {PPP_IDLE, PPP_BUSY, PPP_ERASE} ppp_op_t;
endpackage

/* File: src/ppp_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ppp_params.svh"
module ppp_port
   import ppp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic power_good,
   input wire logic reset_pin_n,
   input wire logic hv_reset,
   input wire logic strobe_clock_pin,
   input wire logic strobe_action_hi,
   input wire logic strobe_action_lo,
   input wire logic byte_select_lo_hi,
   input wire logic byte_select_ext,
   input wire logic page_latch_strobe,
   input wire logic write_n,
   input wire logic out_en_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_n,
   output logic ready_busy_out,
   output logic prog_mode,
   output logic [7:0] fuse_lo_active,
   output logic [7:0] fuse_hi_active,
   output logic keep_eeprom_on_erase,
   output logic [7:0] rc_trim_register
);
   localparam logic [7:0] SIG_B0 = 8'hA5; // Arbitrary identification value
   localparam logic [7:0] SIG_B1 = 8'h5A; // Arbitrary identification value
   localparam logic [7:0] SIG_B2 = 8'h3C; // Arbitrary identification value
   localparam logic [7:0] TRIM1 = 8'h80;
   localparam logic [7:0] TRIM2 = 8'h81;
   localparam logic [7:0] TRIM4 = 8'h82;
   localparam logic [7:0] TRIM8 = 8'h83;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [11:0] s1_ff, s2_ff, s3_ff;
   logic [7:0] d1_ff, d2_ff;
   logic [11:0] raw;
   assign raw = {power_good, reset_pin_n, hv_reset, strobe_clock_pin, strobe_action_hi,
                 strobe_action_lo, byte_select_lo_hi, byte_select_ext, page_latch_strobe,
                 write_n, out_en_n, 1'b0};
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s1_ff <= 12'hFFF;
         s2_ff <= 12'hFFF;
         s3_ff <= 12'hFFF;
         d1_ff <= 8'h00;
         d2_ff <= 8'h00;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         d1_ff <= data_in;
         d2_ff <= d1_ff;
      end
   end
   logic pg, rpin, hv, xa1, xa0, bs1, bs2, pgl, wrn, oen;
   assign pg = s2_ff[11];
   assign rpin = s2_ff[10];
   assign hv = s2_ff[9];
   assign xa1 = s2_ff[7];
   assign xa0 = s2_ff[6];
   assign bs1 = s2_ff[5];
   assign bs2 = s2_ff[4];
   assign pgl = s2_ff[3];
   assign wrn = s2_ff[2];
   assign oen = s2_ff[1];
   logic strobe_rise, pgl_rise, wr_fall;
   assign strobe_rise = s2_ff[8] & ~s3_ff[8];
   assign pgl_rise = pgl & ~s3_ff[3];
   assign wr_fall = ~wrn & s3_ff[2];

   // ------------------------------------------------------------
   // Memories
   // ------------------------------------------------------------
   logic [15:0] prog_mem [0:`PPP_PROG_WORDS-1];
   logic [7:0] ee_mem [0:`PPP_EE_BYTES-1];
   logic [15:0] prog_buf [0:`PPP_PROG_PAGE_WORDS-1];
   logic [7:0] ee_buf [0:`PPP_EE_PAGE_BYTES-1];

   function automatic logic [4:0] word_in_page_index(input logic [15:0] a);
      return a[4:0];
   endfunction
   function automatic logic [6:0] page_index(input logic [15:0] a);
      return a[11:5];
   endfunction

   // ------------------------------------------------------------
   // Mode, fuses and operation state
   // ------------------------------------------------------------
   ppp_mode_t mode_ff, nxt_mode;
   ppp_op_t op_ff, nxt_op;
   logic [3:0] tog_ff, nxt_tog;
   logic [7:0] hold_ff, nxt_hold;
   logic [15:0] busy_ff, nxt_busy;
   logic [12:0] ecnt_ff, nxt_ecnt;
   logic [7:0] cmd_ff, nxt_cmd, alo_ff, nxt_alo, ahi_ff, nxt_ahi;
   logic [7:0] dlo_ff, nxt_dlo, dhi_ff, nxt_dhi;
   logic [7:0] flo_ff, nxt_flo, fhi_ff, nxt_fhi, lock_ff, nxt_lock;
   logic [7:0] flo_act_ff, nxt_flo_act, fhi_act_ff, nxt_fhi_act;
   logic [7:0] trim_ff, nxt_trim;
   logic pwr_done_ff, nxt_pwr_done;
   logic [15:0] addr;
   logic [3:0] entry_pins;
   assign addr = {ahi_ff, alo_ff};
   assign entry_pins = {pgl, xa1, xa0, bs1};

   always_comb begin
      nxt_mode = mode_ff;
      nxt_op = op_ff;
      nxt_tog = tog_ff;
      nxt_hold = hold_ff;
      nxt_busy = busy_ff;
      nxt_ecnt = ecnt_ff;
      nxt_cmd = cmd_ff;
      nxt_alo = alo_ff;
      nxt_ahi = ahi_ff;
      nxt_dlo = dlo_ff;
      nxt_dhi = dhi_ff;
      nxt_flo = flo_ff;
      nxt_fhi = fhi_ff;
      nxt_lock = lock_ff;
      nxt_flo_act = flo_act_ff;
      nxt_fhi_act = fhi_act_ff;
      nxt_trim = trim_ff;
      nxt_pwr_done = pwr_done_ff;
      // Power-up capture in normal mode
      if (pg && !pwr_done_ff) begin
         nxt_flo_act = flo_ff;
         nxt_fhi_act = fhi_ff;
         nxt_trim = TRIM1;
         nxt_pwr_done = 1'b1;
      end
      if (!pg) nxt_pwr_done = 1'b0;
      if (!rpin) nxt_trim = TRIM1;
      case (mode_ff)
         PPP_OFF: begin
            nxt_tog = 4'h0;
            if (!rpin && !hv) nxt_mode = PPP_ARM;
         end
         PPP_ARM: begin
            if (strobe_rise && tog_ff != `PPP_ENTRY_TOGGLES) nxt_tog = tog_ff + 4'h1;
            if (hv) begin
               nxt_hold = 8'h00;
               nxt_mode = (tog_ff == `PPP_ENTRY_TOGGLES && entry_pins == 4'h0) ?
                          PPP_HOLD : PPP_OFF;
            end
         end
         PPP_HOLD: begin
            if (entry_pins != 4'h0 || !hv) nxt_mode = PPP_OFF;
            else if (hold_ff == 8'(`PPP_ENTRY_HOLD_CYC)) begin
               nxt_mode = PPP_ON;
               nxt_flo_act = flo_ff;
               nxt_fhi_act = fhi_ff;
            end else nxt_hold = hold_ff + 8'h01;
         end
         PPP_ON: begin
            if (strobe_rise) begin
               case ({xa1, xa0})
                  `PPP_ACT_ADDR: if (bs1) nxt_ahi = d2_ff; else nxt_alo = d2_ff;
                  `PPP_ACT_DATA: if (bs1) nxt_dhi = d2_ff; else nxt_dlo = d2_ff;
                  `PPP_ACT_CMD: nxt_cmd = d2_ff;
                  default: ;
               endcase
            end
            case (op_ff)
               PPP_IDLE: if (wr_fall) begin
                  case (cmd_ff)
                     `PPP_CMD_ERASE: begin
                        nxt_op = PPP_ERASE;
                        nxt_ecnt = 13'h0000;
                     end
                     `PPP_CMD_WR_FUSE: begin
                        nxt_op = PPP_BUSY;
                        if (bs2) ;
                        else if (bs1) nxt_fhi = dlo_ff;
                        else nxt_flo = dlo_ff;
                        if (!bs2 && bs1) nxt_fhi_act[`PPP_FUSEH_KEEP_EE] =
                           dlo_ff[`PPP_FUSEH_KEEP_EE];
                     end
                     `PPP_CMD_WR_LOCK: begin
                        nxt_op = PPP_BUSY;
                        nxt_lock = lock_ff & dlo_ff;
                     end
                     `PPP_CMD_WR_PROG, `PPP_CMD_WR_EE: nxt_op = PPP_BUSY;
                     default: ;
                  endcase
                  nxt_busy = 16'h0000;
               end
               PPP_BUSY: begin
                  nxt_busy = busy_ff + 16'h0001;
                  if (busy_ff == `PPP_BUSY_CYC) nxt_op = PPP_IDLE;
               end
               PPP_ERASE: begin
                  nxt_ecnt = ecnt_ff + 13'h0001;
                  if (ecnt_ff == 13'(`PPP_PROG_WORDS)) begin
                     nxt_lock = `PPP_LOCK_RST; // Locks cleared after program memory
                     nxt_op = PPP_IDLE;
                  end
               end
               default: nxt_op = PPP_IDLE;
            endcase
         end
         default: nxt_mode = PPP_OFF;
      endcase
      // Arming waits with the reset pin low, so this exit drops it there only on power loss
      if (mode_ff != PPP_OFF && (!pg || (!rpin && mode_ff != PPP_ARM))) begin
         nxt_mode = PPP_OFF;
         nxt_op = PPP_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_ff <= PPP_OFF;
         op_ff <= PPP_IDLE;
         tog_ff <= 4'h0;
         hold_ff <= 8'h00;
         busy_ff <= 16'h0000;
         ecnt_ff <= 13'h0000;
         cmd_ff <= 8'h00;
         alo_ff <= 8'h00;
         ahi_ff <= 8'h00;
         dlo_ff <= 8'h00;
         dhi_ff <= 8'h00;
         flo_ff <= `PPP_FUSE_LO_RST;
         fhi_ff <= `PPP_FUSE_HI_RST;
         lock_ff <= `PPP_LOCK_RST;
         flo_act_ff <= `PPP_FUSE_LO_RST;
         fhi_act_ff <= `PPP_FUSE_HI_RST;
         trim_ff <= TRIM1;
         pwr_done_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         op_ff <= nxt_op;
         tog_ff <= nxt_tog;
         hold_ff <= nxt_hold;
         busy_ff <= nxt_busy;
         ecnt_ff <= nxt_ecnt;
         cmd_ff <= nxt_cmd;
         alo_ff <= nxt_alo;
         ahi_ff <= nxt_ahi;
         dlo_ff <= nxt_dlo;
         dhi_ff <= nxt_dhi;
         flo_ff <= nxt_flo;
         fhi_ff <= nxt_fhi;
         lock_ff <= nxt_lock;
         flo_act_ff <= nxt_flo_act;
         fhi_act_ff <= nxt_fhi_act;
         trim_ff <= nxt_trim;
         pwr_done_ff <= nxt_pwr_done;
      end
   end

   // ------------------------------------------------------------
   // Page buffers and memory arrays
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (mode_ff == PPP_ON && pgl_rise) begin
         if (cmd_ff == `PPP_CMD_WR_EE) ee_buf[alo_ff[1:0]] <= dlo_ff;
         else prog_buf[word_in_page_index(addr)] <= {dhi_ff, dlo_ff};
      end
      if (mode_ff == PPP_ON && op_ff == PPP_IDLE && wr_fall) begin
         if (cmd_ff == `PPP_CMD_WR_PROG) begin
            for (int i = 0; i < `PPP_PROG_PAGE_WORDS; i++)
               prog_mem[{page_index(addr), 5'(i)}] <= prog_buf[i];
         end
         if (cmd_ff == `PPP_CMD_WR_EE) begin
            for (int i = 0; i < `PPP_EE_PAGE_BYTES; i++)
               ee_mem[{addr[8:2], 2'(i)}] <= ee_buf[i];
         end
      end
      if (op_ff == PPP_ERASE && ecnt_ff < 13'(`PPP_PROG_WORDS)) begin
         prog_mem[ecnt_ff[11:0]] <= {`PPP_ERASED, `PPP_ERASED};
         if (ecnt_ff < 13'(`PPP_EE_BYTES) && !fhi_act_ff[`PPP_FUSEH_KEEP_EE])
            ;
         else if (ecnt_ff < 13'(`PPP_EE_BYTES) && fhi_ff[`PPP_FUSEH_KEEP_EE])
            ee_mem[ecnt_ff[8:0]] <= `PPP_ERASED;
      end
   end

   // ------------------------------------------------------------
   // Read data path
   // ------------------------------------------------------------
   logic [7:0] nxt_dout, dout_ff;
   logic [15:0] pword;
   assign pword = prog_mem[addr[11:0]];
   always_comb begin
      nxt_dout = 8'h00;
      case (cmd_ff)
         `PPP_CMD_RD_SIG: begin
            if (bs1) begin
               case (alo_ff)
                  8'h00: nxt_dout = TRIM1;
                  8'h01: nxt_dout = TRIM2;
                  8'h02: nxt_dout = TRIM4;
                  8'h03: nxt_dout = TRIM8;
                  default: nxt_dout = 8'h00;
               endcase
            end else begin
               case (alo_ff[1:0])
                  2'h0: nxt_dout = SIG_B0;
                  2'h1: nxt_dout = SIG_B1;
                  `PPP_SIG_LAST: nxt_dout = SIG_B2;
                  default: nxt_dout = 8'h00;
               endcase
            end
         end
         `PPP_CMD_RD_FUSE: nxt_dout = bs2 ? lock_ff : (bs1 ? fhi_ff : flo_ff);
         `PPP_CMD_RD_PROG: nxt_dout = bs1 ? pword[15:8] : pword[7:0];
         `PPP_CMD_RD_EE: nxt_dout = ee_mem[addr[8:0]];
         default: nxt_dout = 8'h00;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) dout_ff <= 8'h00;
      else dout_ff <= nxt_dout;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign data_out = dout_ff;
   assign data_oe_n = ~(mode_ff == PPP_ON && !oen);
   assign ready_busy_out = (op_ff == PPP_IDLE);
   assign prog_mode = (mode_ff == PPP_ON);
   assign fuse_lo_active = flo_act_ff;
   assign fuse_hi_active = fhi_act_ff;
   assign keep_eeprom_on_erase = ~fhi_act_ff[`PPP_FUSEH_KEEP_EE];
   assign rc_trim_register = trim_ff;
endmodule // ppp_port
`default_nettype wire

/* File: verif/ppp_port_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module ppp_port_monitor
   import ppp_pkg::*;
#(
   parameter logic [7:0] TRIM_1MHZ = 8'h80
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reset_pin_n,
   input wire logic hv_reset,
   input wire logic strobe_action_hi,
   input wire logic strobe_action_lo,
   input wire logic byte_select_lo_hi,
   input wire logic page_latch_strobe,
   input wire logic write_n,
   input wire logic out_en_n,
   input wire logic data_oe_n,
   input wire logic ready_busy_out,
   input wire logic prog_mode,
   input wire logic [7:0] fuse_lo_active,
   input wire logic [7:0] fuse_hi_active,
   input wire logic keep_eeprom_on_erase,
   input wire logic [7:0] rc_trim_register
);
   // ---------------------------------
   // Busy length counter
   // ---------------------------------
   logic [15:0] busy_cnt_ff;
   logic [15:0] nxt_busy_cnt;
   always_comb begin
      nxt_busy_cnt = ready_busy_out ? 16'h0000 : busy_cnt_ff + 16'h0001;
   end
   always_ff @(posedge core_clk) begin
      busy_cnt_ff <= rst_n ? nxt_busy_cnt : 16'h0000;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_DRIVE_IN_MODE: assert property (!data_oe_n |-> prog_mode)
      else $error("Bus driven outside programming mode");
   AST_DRIVE_ON_OE: assert property (!data_oe_n |-> !out_en_n || !$past(out_en_n) ||
      !$past(out_en_n, 2) || !$past(out_en_n, 3)) else $error("Bus driven without enable");
   AST_BUSY_CAUSE: assert property ($fell(ready_busy_out) |-> prog_mode &&
      !($past(write_n) && $past(write_n, 3) && $past(write_n, 6))) else $error("Busy uncaused");
   AST_BUSY_MIN: assert property ($rose(ready_busy_out) |-> $past(busy_cnt_ff) >= 16'h00F0)
      else $error("Busy too short");
   AST_BUSY_MAX: assert property (busy_cnt_ff < 16'h2000)
      else $error("Busy never ends");
   AST_FUSE_HELD: assert property (prog_mode && $past(prog_mode) |->
      $stable(fuse_lo_active) && $stable({fuse_hi_active[7:4], fuse_hi_active[2:0]}))
      else $error("Fuses moved in mode");
   AST_KEEP_OUT: assert property (!prog_mode && !$past(prog_mode) && !$past(prog_mode, 3) |->
      keep_eeprom_on_erase == !fuse_hi_active[3]) else $error("Keep flag off fuse");
   AST_ENTRY_PINS: assert property ($rose(prog_mode) |-> hv_reset && reset_pin_n &&
      !page_latch_strobe && !strobe_action_hi && !strobe_action_lo && !byte_select_lo_hi)
      else $error("Entry with bad pins");
   AST_EXIT: assert property ((!reset_pin_n) [*6] |-> !prog_mode)
      else $error("Mode kept in reset");
   AST_TRIM_SET: assert property ($rose(rst_n) |-> rc_trim_register == TRIM_1MHZ)
      else $error("Trim not loaded");
   cover property ($rose(prog_mode));
   cover property ($fell(ready_busy_out));
   cover property ($fell(data_oe_n));
endmodule // ppp_port_monitor
bind ppp_port ppp_port_monitor #(.TRIM_1MHZ(8'h80)) u_mon (.core_clk(core_clk), .rst_n(rst_n),
   .reset_pin_n(reset_pin_n), .hv_reset(hv_reset), .strobe_action_hi(strobe_action_hi),
   .strobe_action_lo(strobe_action_lo), .byte_select_lo_hi(byte_select_lo_hi),
   .page_latch_strobe(page_latch_strobe), .write_n(write_n), .out_en_n(out_en_n),
   .data_oe_n(data_oe_n), .ready_busy_out(ready_busy_out), .prog_mode(prog_mode),
   .fuse_lo_active(fuse_lo_active), .fuse_hi_active(fuse_hi_active),
   .keep_eeprom_on_erase(keep_eeprom_on_erase), .rc_trim_register(rc_trim_register));
`default_nettype wire

/* File: verif/ppp_programmer.sv */
`timescale 1ns/1ns
`default_nettype none
module ppp_programmer (
   input wire logic core_clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   input wire logic ready_busy_out,
   output logic power_good,
   output logic reset_pin_n,
   output logic hv_reset,
   output logic strobe_clock_pin,
   output logic strobe_action_hi,
   output logic strobe_action_lo,
   output logic byte_select_lo_hi,
   output logic byte_select_ext,
   output logic page_latch_strobe,
   output logic write_n,
   output logic out_en_n,
   output logic [7:0] data_in
);
   logic [7:0] drv = 8'h00;
   // Set when a wait for ready runs out
   logic timed_out = 1'b0;
   // Bus: device value, ours, or a released bus
   assign data_in = !data_oe_n ? data_out : (out_en_n ? drv : ~drv);
   // Idle pin levels, normal mode
   initial begin
      power_good = 1'b1;
      reset_pin_n = 1'b1;
      hv_reset = 1'b0;
      strobe_clock_pin = 1'b0;
      {strobe_action_hi, strobe_action_lo} = 2'h3;
      byte_select_lo_hi = 1'b0;
      byte_select_ext = 1'b0;
      page_latch_strobe = 1'b0;
      write_n = 1'b1;
      out_en_n = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // One byte in, action chosen by the selects
   task automatic strobe(input logic [1:0] act, input logic bs1, input logic [7:0] val);
      {strobe_action_hi, strobe_action_lo} = act;
      byte_select_lo_hi = bs1;
      drv = val;
      step(8);
      strobe_clock_pin = 1'b1;
      step(8);
      strobe_clock_pin = 1'b0;
      step(8);
   endtask
   task automatic latch_page();
      page_latch_strobe = 1'b1;
      step(8);
      page_latch_strobe = 1'b0;
      step(8);
   endtask
   // Write pulse, then a bounded wait for ready
   task automatic pulse_write(input logic bs1, output logic busy, output logic done);
      byte_select_lo_hi = bs1;
      step(8);
      write_n = 1'b0;
      step(8);
      busy = !ready_busy_out;
      write_n = 1'b1;
      for (int i = 0; i < 6000 && !ready_busy_out; i++) step(1);
      done = ready_busy_out;
      if (!done) timed_out = 1'b1;
      step(8);
   endtask
   task automatic read(input logic bs1, input logic bs2, output logic [7:0] v, output logic oe);
      byte_select_lo_hi = bs1;
      byte_select_ext = bs2;
      out_en_n = 1'b0;
      step(8);
      v = data_in;
      oe = data_oe_n;
      out_en_n = 1'b1;
      byte_select_ext = 1'b0;
      step(8);
   endtask
   // Entry; glitch moves a pattern pin too early
   task automatic enter(input logic glitch);
      reset_pin_n = 1'b0;
      step(8);
      for (int i = 0; i < 6; i++) begin
         strobe_clock_pin = 1'b1;
         step(8);
         strobe_clock_pin = 1'b0;
         step(8);
      end
      {page_latch_strobe, strobe_action_hi, strobe_action_lo, byte_select_lo_hi} = 4'h0;
      step(8);
      reset_pin_n = 1'b1;
      hv_reset = 1'b1;
      step(4);
      byte_select_lo_hi = glitch;
      step(40);
      byte_select_lo_hi = 1'b0;
      step(8);
   endtask
   task automatic leave();
      hv_reset = 1'b0;
      reset_pin_n = 1'b0;
      step(16);
   endtask
endmodule // ppp_programmer
`default_nettype wire

/* File: verif/test_ppp_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ppp_params.svh"
module test_ppp_port;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic power_good, reset_pin_n, hv_reset, strobe_clock_pin, strobe_action_hi;
   logic strobe_action_lo, byte_select_lo_hi, byte_select_ext, page_latch_strobe;
   logic write_n, out_en_n, data_oe_n, ready_busy_out, prog_mode, keep_eeprom_on_erase;
   logic [7:0] data_in, data_out, fuse_lo_active, fuse_hi_active, rc_trim_register;
   logic [7:0] v;
   logic oe, busy, done;
   int fail_count = 0;
   int tests_run = 0;
   always #2 core_clk = ~core_clk;
   ppp_port uut (.core_clk(core_clk), .rst_n(rst_n), .power_good(power_good),
      .reset_pin_n(reset_pin_n), .hv_reset(hv_reset), .strobe_clock_pin(strobe_clock_pin),
      .strobe_action_hi(strobe_action_hi), .strobe_action_lo(strobe_action_lo),
      .byte_select_lo_hi(byte_select_lo_hi), .byte_select_ext(byte_select_ext),
      .page_latch_strobe(page_latch_strobe), .write_n(write_n), .out_en_n(out_en_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .ready_busy_out(ready_busy_out), .prog_mode(prog_mode), .fuse_lo_active(fuse_lo_active),
      .fuse_hi_active(fuse_hi_active), .keep_eeprom_on_erase(keep_eeprom_on_erase),
      .rc_trim_register(rc_trim_register));
   ppp_programmer pgm (.core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n),
      .ready_busy_out(ready_busy_out), .power_good(power_good), .reset_pin_n(reset_pin_n),
      .hv_reset(hv_reset), .strobe_clock_pin(strobe_clock_pin),
      .strobe_action_hi(strobe_action_hi), .strobe_action_lo(strobe_action_lo),
      .byte_select_lo_hi(byte_select_lo_hi), .byte_select_ext(byte_select_ext),
      .page_latch_strobe(page_latch_strobe), .write_n(write_n), .out_en_n(out_en_n),
      .data_in(data_in));
   // ---------------------------------
   // Compare, close, helpers
   // ---------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      pgm.strobe(2'h2, 1'b0, c);
   endtask
   task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
      pgm.strobe(2'h0, 1'b1, hi);
      pgm.strobe(2'h0, 1'b0, lo);
   endtask
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic t_reset_refused();
      check(fuse_lo_active, `PPP_FUSE_LO_RST);
      check(fuse_hi_active, `PPP_FUSE_HI_RST);
      check(rc_trim_register, 8'h80);
      check({4'h0, ready_busy_out, prog_mode, data_oe_n, keep_eeprom_on_erase}, 8'h0A);
      pgm.pulse_write(1'b0, busy, done);
      check({6'h00, busy, done}, 8'h01);
   endtask
   task automatic t_entry();
      pgm.enter(1'b1);
      check({7'h00, prog_mode}, 8'h00);
      pgm.leave();
      pgm.enter(1'b0);
      check({7'h00, prog_mode}, 8'h01);
   endtask
   task automatic t_trim();
      cmd(`PPP_CMD_RD_SIG);
      addr(8'h00, 8'h00);
      pgm.read(1'b1, 1'b0, v, oe);
      check(v, 8'h80);
      check({7'h00, oe}, 8'h00);
      pgm.strobe(2'h3, 1'b0, 8'h03);
      pgm.read(1'b1, 1'b0, v, oe);
      check(v, 8'h80);
      check({7'h00, data_oe_n}, 8'h01);
   endtask
   task automatic t_prog_ee();
      cmd(`PPP_CMD_WR_PROG);
      addr(8'h00, 8'h25);
      pgm.strobe(2'h1, 1'b0, 8'h5A);
      pgm.strobe(2'h1, 1'b1, 8'hC3);
      pgm.latch_page();
      pgm.pulse_write(1'b0, busy, done);
      check({6'h00, busy, done}, 8'h03);
      cmd(`PPP_CMD_RD_PROG);
      pgm.read(1'b0, 1'b0, v, oe);
      check(v, 8'h5A);
      pgm.read(1'b1, 1'b0, v, oe);
      check(v, 8'hC3);
      cmd(`PPP_CMD_WR_EE);
      addr(8'h01, 8'h02);
      pgm.strobe(2'h1, 1'b0, 8'h96);
      pgm.latch_page();
      pgm.pulse_write(1'b0, busy, done);
      check({6'h00, busy, done}, 8'h03);
      cmd(`PPP_CMD_RD_EE);
      pgm.read(1'b0, 1'b0, v, oe);
      check(v, 8'h96);
   endtask
   task automatic t_fuse_erase_exit();
      cmd(`PPP_CMD_WR_FUSE);
      pgm.strobe(2'h1, 1'b0, 8'hC1);
      pgm.pulse_write(1'b1, busy, done);
      check({7'h00, keep_eeprom_on_erase}, 8'h01);
      check(fuse_hi_active, 8'hD1);
      pgm.strobe(2'h1, 1'b0, 8'hE0);
      pgm.pulse_write(1'b0, busy, done);
      check(fuse_lo_active, `PPP_FUSE_LO_RST);
      cmd(`PPP_CMD_RD_FUSE);
      pgm.read(1'b0, 1'b0, v, oe);
      check(v, 8'hE0);
      pgm.read(1'b1, 1'b0, v, oe);
      check(v, 8'hC1);
      pgm.read(1'b0, 1'b1, v, oe);
      check(v, `PPP_LOCK_RST);
      cmd(`PPP_CMD_ERASE);
      pgm.pulse_write(1'b0, busy, done);
      check({6'h00, busy, done}, 8'h03);
      cmd(`PPP_CMD_RD_EE);
      pgm.read(1'b0, 1'b0, v, oe);
      check(v, 8'h96);
      cmd(`PPP_CMD_RD_PROG);
      addr(8'h00, 8'h25);
      pgm.read(1'b0, 1'b0, v, oe);
      check(v, `PPP_ERASED);
      pgm.leave();
      check({7'h00, prog_mode}, 8'h00);
      check(fuse_hi_active, 8'hD1);
      pgm.enter(1'b0);
      check(fuse_hi_active, 8'hC1);
      check(fuse_lo_active, 8'hE0);
   endtask
   // Watchdog against a hang or a ready wait that ran out
   initial begin
      for (int i = 0; i < 100000 && !pgm.timed_out; i++) @(posedge core_clk);
      fail_count++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      pgm.step(4);
      t_reset_refused();
      t_entry();
      t_trim();
      t_prog_ee();
      t_fuse_erase_exit();
      finish_test();
   end
endmodule // test_ppp_port
`default_nettype wire
